/* include/cswt_defines.vh */
// Register map, field positions and timing constants of the wake timer block
`ifndef CSWT_DEFINES_VH
`define CSWT_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CSWT_OFF_FIRST_TIMER    12'h000
`define CSWT_OFF_SECOND_TIMER   12'h004
`define CSWT_OFF_WAKE_SRC       12'h008
`define CSWT_OFF_HS_MAP         12'h00C
`define CSWT_OFF_FLAGS_A        12'h010
`define CSWT_OFF_FLAGS_B        12'h014
`define CSWT_OFF_LEVELS         12'h018
`define CSWT_OFF_STATUS         12'h01C

// ----------------------------------------------------------------
// Timer setup fields: period [2:0], on-time [6:4]
// ----------------------------------------------------------------
`define CSWT_PER_LSB            0
`define CSWT_ON_LSB             4
`define CSWT_ON_OFF_LOW         3'h0
`define CSWT_ON_OFF_HIGH        3'h7
`define CSWT_TIMER_RST          7'h00

// ----------------------------------------------------------------
// Flags A: [2:0] wake input events; B: [1:0] timer wake events
// Status: [0] on-time exceeds period error, [1] sleep request blocked
// ----------------------------------------------------------------
`define CSWT_ST_ERR_BIT         0
`define CSWT_ST_BLK_BIT         1

// ----------------------------------------------------------------
// Timing (clock 250 MHz, 4 ns)
// ----------------------------------------------------------------
`define CSWT_CLK_PERIOD_NS      4
`define CSWT_TICK_NS            100000
`define CSWT_TICK_CYC           (`CSWT_TICK_NS / `CSWT_CLK_PERIOD_NS)
`define CSWT_FILTER_NS          16000
`define CSWT_FILTER_CYC         (`CSWT_FILTER_NS / `CSWT_CLK_PERIOD_NS)

// Device modes
`define CSWT_MODE_NORMAL        2'h0
`define CSWT_MODE_STOP          2'h1
`define CSWT_MODE_SLEEP         2'h2
`define CSWT_MODE_FAILSAFE      2'h3

`endif

/* rtl/cswt_tick_gen.v */
// Prescaler producing a 0.1 ms tick for the wake timers
`timescale 1ns/100ps
`include "cswt_defines.vh"

module cswt_tick_gen #(
  parameter TICK_CYC = `CSWT_TICK_CYC
) (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Tick out
  output reg  tick_ff
);

  reg [16:0] cnt_ff;
  wire       wrap = (cnt_ff == TICK_CYC - 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 17'h00000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= wrap ? 17'h00000 : cnt_ff + 17'h00001;
      tick_ff <= wrap;
    end
  end

endmodule // cswt_tick_gen

/* rtl/cswt_timer.v */
// One wake timer: period and on-time in 0.1 ms ticks
`timescale 1ns/100ps
`include "cswt_defines.vh"

module cswt_timer (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Control
  input  wire       tick,
  input  wire [2:0] period_sel,
  input  wire [2:0] on_sel,
  // Status
  output reg        on_ff,
  output reg        start_ff,
  output reg        end_ff,
  output wire       running,
  output wire       too_long
);

  function [15:0] per_ticks;
    input [2:0] s;
    begin
      case (s)
        3'h0:    per_ticks = 16'h0064;
        3'h1:    per_ticks = 16'h00C8;
        3'h2:    per_ticks = 16'h01F4;
        3'h3:    per_ticks = 16'h03E8;
        3'h4:    per_ticks = 16'h07D0;
        3'h5:    per_ticks = 16'h2710;
        default: per_ticks = 16'h4E20;
      endcase
    end
  endfunction

  function [15:0] on_ticks;
    input [2:0] s;
    begin
      case (s)
        3'h1:    on_ticks = 16'h0001;
        3'h2:    on_ticks = 16'h0003;
        3'h3:    on_ticks = 16'h000A;
        3'h4:    on_ticks = 16'h0064;
        3'h5:    on_ticks = 16'h00C8;
        default: on_ticks = 16'h0000;
      endcase
    end
  endfunction

  reg  [15:0] cnt_ff;
  wire [15:0] per = per_ticks(period_sel);
  wire [15:0] ont = on_ticks(on_sel);

  // Off codes and unused codes keep the timer idle
  assign running  = (ont != 16'h0000);
  assign too_long = running && (ont > per);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff   <= 16'h0000;
      on_ff    <= 1'b0;
      start_ff <= 1'b0;
      end_ff   <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      end_ff   <= 1'b0;
      if (!running) begin
        cnt_ff <= 16'h0000;
        on_ff  <= 1'b0;
      end else if (tick) begin
        // Off at the tick after ont ticks, so a one-tick on-time still pulses
        if (cnt_ff == 16'h0000) begin
          on_ff    <= 1'b1;
          start_ff <= 1'b1;
        end else if (cnt_ff == ont) begin
          on_ff  <= 1'b0;
          end_ff <= 1'b1;
        end
        cnt_ff <= (cnt_ff + 16'h0001 >= per) ? 16'h0000
                                             : cnt_ff + 16'h0001;
      end
    end
  end

endmodule // cswt_timer

/* rtl/cswt_top.v */
// Cyclic sense and cyclic wake timer block with APB register access
//
// Behaviour
// - Timer runs once non-off on-time written
// - Periods 10,20,50,100,200 ms, 1,2 s
// - On-times 0.1..20 ms plus off low/high
// - Off setting holds switch at idle level
// - Error flag when on-time exceeds period
// - First sample is reference; change wakes
// - 16 us filter after on-time, stable required
// - Wake sets per-input event flag
// - Level status updated only on samples
// - Fail-safe disables switch and sensing
// - Switch faults disable that switch
// - Timers keep running after switch fault
// - Stop gives interrupt, sleep gives wake-up
// - Uncleared flags make sleep wake at once
// - Enabled timer gives periodic interrupt
// - Interrupt each on-time start but first
// - Timers mappable to switches by register
`timescale 1ns/100ps
`include "cswt_defines.vh"

module cswt_top #(
  parameter NUM_WAKE = 3,
  parameter NUM_HS   = 4,
  parameter TICK_CYC = `CSWT_TICK_CYC
) (
  // Clock and reset
  input  wire                pclk,
  input  wire                presetn,
  // APB slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  // Device mode and faults
  input  wire [1:0]          dev_mode,
  input  wire                sleep_req,
  input  wire [NUM_HS-1:0]   hs_fault,
  // Wake inputs
  input  wire [NUM_WAKE-1:0] wake_input_pin,
  // Switch outputs and events
  output reg  [NUM_HS-1:0]   high_side_switch,
  output reg                 int_req_ff,
  output reg                 supply_wake_ff
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [6:0]           first_timer_setup;
  reg [6:0]           second_timer_setup;
  reg [1:0]           wake_source_enable_ctrl;
  reg [2*NUM_HS-1:0]  high_side_timer_map;
  reg [NUM_WAKE-1:0]  wake_event_flags_a;
  reg [1:0]           wake_event_flags_b;
  reg [NUM_WAKE-1:0]  wake_input_level_flags;
  reg                 err_ff;
  reg                 blk_ff;
  reg [NUM_HS-1:0]    hs_dis_ff;
  reg [NUM_WAKE-1:0]  ref_ff;
  reg [NUM_WAKE-1:0]  ref_ok_ff;
  reg [NUM_WAKE-1:0]  samp_ff;
  reg [NUM_WAKE-1:0]  flt_bad_ff;
  reg [12:0]          flt_cnt_ff;
  reg                 flt_act_ff;
  reg [1:0]           first_seen_ff;
  reg [1:0]           mode_q_ff;

  wire       tick;
  wire [1:0] t_on;
  wire [1:0] t_start;
  wire [1:0] t_end;
  wire [1:0] t_run;
  wire [1:0] t_long;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  cswt_tick_gen #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick_ff (tick)
  );

  // Fail-safe stops cyclic operation; switch faults leave timers running
  wire fs = (dev_mode == `CSWT_MODE_FAILSAFE);

  cswt_timer u_t1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (tick),
    .period_sel (first_timer_setup[2:0]),
    .on_sel     (fs ? `CSWT_ON_OFF_LOW : first_timer_setup[6:4]),
    .on_ff      (t_on[0]),
    .start_ff   (t_start[0]),
    .end_ff     (t_end[0]),
    .running    (t_run[0]),
    .too_long   (t_long[0])
  );

  cswt_timer u_t2 (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (tick),
    .period_sel (second_timer_setup[2:0]),
    .on_sel     (fs ? `CSWT_ON_OFF_LOW : second_timer_setup[6:4]),
    .on_ff      (t_on[1]),
    .start_ff   (t_start[1]),
    .end_ff     (t_end[1]),
    .running    (t_run[1]),
    .too_long   (t_long[1])
  );

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  wire setup  = psel && !penable;
  wire access = psel && penable && pready;
  wire wr     = access && pwrite;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `CSWT_OFF_STATUS);
    end
  endfunction

  // ----------------------------------------------------------------
  // Switch drive
  // ----------------------------------------------------------------
  // Idle level of a timer from its off code
  wire [1:0] idle_hi;
  assign idle_hi[0] = (first_timer_setup[6:4] == `CSWT_ON_OFF_HIGH);
  assign idle_hi[1] = (second_timer_setup[6:4] == `CSWT_ON_OFF_HIGH);

  // Map field per switch: 0 none, 1 timer one, 2 timer two
  reg [NUM_HS-1:0] nxt_hs;
  integer i;
  always @* begin
    nxt_hs = {NUM_HS{1'b0}};
    for (i = 0; i < NUM_HS; i = i + 1) begin
      case (high_side_timer_map[2*i +: 2])
        2'h1:    nxt_hs[i] = t_run[0] ? t_on[0] : idle_hi[0];
        2'h2:    nxt_hs[i] = t_run[1] ? t_on[1] : idle_hi[1];
        default: nxt_hs[i] = 1'b0;
      endcase
      if (hs_dis_ff[i] || fs)
        nxt_hs[i] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sampling and filter
  // ----------------------------------------------------------------
  // Timers used for sensing are those mapped to any switch
  reg [1:0] sense_t;
  integer j;
  always @* begin
    sense_t = 2'h0;
    for (j = 0; j < NUM_HS; j = j + 1) begin
      if (high_side_timer_map[2*j +: 2] == 2'h1)
        sense_t[0] = 1'b1;
      if (high_side_timer_map[2*j +: 2] == 2'h2)
        sense_t[1] = 1'b1;
    end
  end

  wire flt_start = |(t_end & sense_t) && !fs;
  wire flt_done  = flt_act_ff &&
                   (flt_cnt_ff == `CSWT_FILTER_CYC - 1);
  wire [NUM_WAKE-1:0] stable = ~flt_bad_ff &
                               ~(samp_ff ^ wake_input_pin);
  wire [NUM_WAKE-1:0] wake_hit = {NUM_WAKE{flt_done}} & stable &
                                 ref_ok_ff & (samp_ff ^ ref_ff);

  // Cyclic wake events, first start after timer start skipped
  wire [1:0] cyc_evt = t_start & first_seen_ff &
                       wake_source_enable_ctrl;

  wire low_pwr_ok = (dev_mode == `CSWT_MODE_NORMAL) ||
                    (dev_mode == `CSWT_MODE_STOP);

  // Sleep entry with pending flags is turned into a wake
  wire pend = |wake_event_flags_a || |wake_event_flags_b;
  wire sleep_entry = (dev_mode == `CSWT_MODE_SLEEP) &&
                     (mode_q_ff != `CSWT_MODE_SLEEP);

  reg [31:0] rd;
  always @* begin
    case (paddr)
      `CSWT_OFF_FIRST_TIMER:  rd = {25'h0, first_timer_setup};
      `CSWT_OFF_SECOND_TIMER: rd = {25'h0, second_timer_setup};
      `CSWT_OFF_WAKE_SRC:     rd = {30'h0, wake_source_enable_ctrl};
      `CSWT_OFF_HS_MAP: rd = {{(32-2*NUM_HS){1'b0}}, high_side_timer_map};
      `CSWT_OFF_FLAGS_A: rd = {{(32-NUM_WAKE){1'b0}}, wake_event_flags_a};
      `CSWT_OFF_FLAGS_B:      rd = {30'h0, wake_event_flags_b};
      `CSWT_OFF_LEVELS:
        rd = {{(32-NUM_WAKE){1'b0}}, wake_input_level_flags};
      `CSWT_OFF_STATUS:       rd = {30'h0, blk_ff, err_ff};
      default:                rd = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequential logic
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_timer_setup       <= `CSWT_TIMER_RST;
      second_timer_setup      <= `CSWT_TIMER_RST;
      wake_source_enable_ctrl <= 2'h0;
      high_side_timer_map     <= {2*NUM_HS{1'b0}};
      wake_event_flags_a      <= {NUM_WAKE{1'b0}};
      wake_event_flags_b      <= 2'h0;
      wake_input_level_flags  <= {NUM_WAKE{1'b0}};
      err_ff                  <= 1'b0;
      blk_ff                  <= 1'b0;
      hs_dis_ff               <= {NUM_HS{1'b0}};
      ref_ff                  <= {NUM_WAKE{1'b0}};
      ref_ok_ff               <= {NUM_WAKE{1'b0}};
      samp_ff                 <= {NUM_WAKE{1'b0}};
      flt_bad_ff              <= {NUM_WAKE{1'b0}};
      flt_cnt_ff              <= 13'h0000;
      flt_act_ff              <= 1'b0;
      first_seen_ff           <= 2'h0;
      mode_q_ff               <= `CSWT_MODE_NORMAL;
      high_side_switch        <= {NUM_HS{1'b0}};
      int_req_ff              <= 1'b0;
      supply_wake_ff          <= 1'b0;
      prdata                  <= 32'h00000000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
    end else begin
      // No wait state: ready rises the cycle after setup
      pready   <= setup;
      pslverr  <= setup && !mapped(paddr);
      prdata   <= (setup && !pwrite) ? rd : 32'h00000000;
      mode_q_ff <= dev_mode;
      high_side_switch <= nxt_hs;

      if (wr && paddr == `CSWT_OFF_FIRST_TIMER)
        first_timer_setup <= pwdata[6:0];
      if (wr && paddr == `CSWT_OFF_SECOND_TIMER)
        second_timer_setup <= pwdata[6:0];
      if (wr && paddr == `CSWT_OFF_WAKE_SRC)
        wake_source_enable_ctrl <= pwdata[1:0];
      if (wr && paddr == `CSWT_OFF_HS_MAP)
        high_side_timer_map <= pwdata[2*NUM_HS-1:0];

      // Error is sticky; write one to clear, a new error wins
      if (|t_long)
        err_ff <= 1'b1;
      else if (wr && paddr == `CSWT_OFF_STATUS &&
               pwdata[`CSWT_ST_ERR_BIT])
        err_ff <= 1'b0;
      if (sleep_entry && pend)
        blk_ff <= 1'b1;
      else if (wr && paddr == `CSWT_OFF_STATUS &&
               pwdata[`CSWT_ST_BLK_BIT])
        blk_ff <= 1'b0;

      // Fault latches the switch off until the map is rewritten
      if (wr && paddr == `CSWT_OFF_HS_MAP)
        hs_dis_ff <= hs_fault;
      else if (dev_mode != `CSWT_MODE_FAILSAFE)
        hs_dis_ff <= hs_dis_ff | hs_fault;

      // First start of each timer is not reported
      first_seen_ff <= (first_seen_ff | t_start) & t_run;

      // Filter window after each sensing on-time
      if (flt_start) begin
        flt_act_ff <= 1'b1;
        flt_cnt_ff <= 13'h0000;
        samp_ff    <= wake_input_pin;
        flt_bad_ff <= {NUM_WAKE{1'b0}};
      end else if (flt_act_ff) begin
        flt_bad_ff <= flt_bad_ff | (samp_ff ^ wake_input_pin);
        flt_cnt_ff <= flt_cnt_ff + 13'h0001;
        if (flt_done)
          flt_act_ff <= 1'b0;
      end

      // Stable samples become the reference for next cycle
      if (flt_done) begin
        ref_ff    <= (ref_ff & ~stable) | (samp_ff & stable);
        ref_ok_ff <= ref_ok_ff | stable;
        if (low_pwr_ok)
          wake_input_level_flags <= (wake_input_level_flags & ~stable) |
                                    (samp_ff & stable);
      end
      if (fs) begin
        ref_ok_ff  <= {NUM_WAKE{1'b0}};
        flt_act_ff <= 1'b0;
      end

      // Event flags: set wins over write-one-to-clear
      wake_event_flags_a <= (wake_event_flags_a &
        ~((wr && paddr == `CSWT_OFF_FLAGS_A) ?
          pwdata[NUM_WAKE-1:0] : {NUM_WAKE{1'b0}})) | wake_hit;
      wake_event_flags_b <= (wake_event_flags_b &
        ~((wr && paddr == `CSWT_OFF_FLAGS_B) ?
          pwdata[1:0] : 2'h0)) | (low_pwr_ok ? cyc_evt : 2'h0);

      // Interrupt in normal/stop, supply wake from sleep
      int_req_ff <= low_pwr_ok &&
                    ((|wake_hit) || (|cyc_evt));
      supply_wake_ff <= (dev_mode == `CSWT_MODE_SLEEP) &&
                        ((|wake_hit) || (sleep_entry && pend));
    end
  end

endmodule // cswt_top

/* sim/cswt_monitor.sv */
// Port-level assertions for the wake timer block
`timescale 1ns/100ps
`include "cswt_defines.vh"

module cswt_monitor #(
  parameter NUM_WAKE = 3,
  parameter NUM_HS   = 4,
  parameter TICK_CYC = 10
) (
  // Clock and reset
  input wire                pclk,
  input wire                presetn,
  // APB
  input wire                psel,
  input wire                penable,
  input wire [11:0]         paddr,
  input wire [31:0]         prdata,
  input wire                pready,
  input wire                pslverr,
  // Mode and switches
  input wire [1:0]          dev_mode,
  input wire [NUM_HS-1:0]   hs_fault,
  input wire [NUM_HS-1:0]   high_side_switch,
  input wire                int_req_ff,
  input wire                supply_wake_ff
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------
  // Checks
  // ------
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_error_decode: assert property (pready |->
    pslverr == (paddr > `CSWT_OFF_STATUS || paddr[1:0] != 2'h0))
    else $error("error response wrong");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_irq_pulse: assert property (int_req_ff |=> !int_req_ff)
    else $error("interrupt longer than a cycle");
  chk_irq_awake: assert property (int_req_ff |->
    $past(dev_mode) inside {`CSWT_MODE_NORMAL, `CSWT_MODE_STOP})
    else $error("interrupt outside normal or stop");
  chk_wake_sleep: assert property (supply_wake_ff |->
    $past(dev_mode) == `CSWT_MODE_SLEEP ##1 !supply_wake_ff)
    else $error("supply wake outside sleep");
  chk_failsafe_off: assert property (
    (dev_mode == `CSWT_MODE_FAILSAFE) [*2] |=> high_side_switch == 0)
    else $error("switch on in fail-safe");
  chk_fault_off: assert property (hs_fault[0] [*2] |=>
    !high_side_switch[0])
    else $error("faulted switch still on");
  cover property (int_req_ff);
  cover property (supply_wake_ff);
  cover property (pready && pslverr);
endmodule // cswt_monitor

bind cswt_top cswt_monitor #(
  .NUM_WAKE(NUM_WAKE), .NUM_HS(NUM_HS), .TICK_CYC(TICK_CYC)
) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dev_mode(dev_mode), .hs_fault(hs_fault),
  .high_side_switch(high_side_switch), .int_req_ff(int_req_ff),
  .supply_wake_ff(supply_wake_ff)
);

/* sim/cswt_wake_network.sv */
// Contact network model on the wake inputs
`timescale 1ns/100ps

module cswt_wake_network #(
  parameter NUM_WAKE = 3
) (
  // Clock
  input  wire                 pclk,
  // Scenario controls
  input  wire  [NUM_WAKE-1:0] closed,
  input  wire  [NUM_WAKE-1:0] chatter,
  // Wake lines
  output logic [NUM_WAKE-1:0] wake_input_pin
);
  // Contacts short to ground against a pull-up, so closed reads low;
  // chatter flips the line every cycle so no filter window is stable
  logic toggle = 1'h0;
  always @(posedge pclk) toggle <= ~toggle;
  assign wake_input_pin = ~closed ^ (chatter & {NUM_WAKE{toggle}});
endmodule // cswt_wake_network

/* sim/cyclic_sense_wake_timer_bench.sv */
// Self-checking bench for the cyclic sense and wake timer block
`timescale 1ns/100ps
`include "cswt_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module cyclic_sense_wake_timer_bench;
  // ------
  // Setup
  // ------
  localparam int TICK = 10;
  localparam logic [11:0] T1 = `CSWT_OFF_FIRST_TIMER;
  localparam logic [11:0] MAP = `CSWT_OFF_HS_MAP;
  localparam logic [11:0] FLA = `CSWT_OFF_FLAGS_A;
  localparam logic [11:0] FLB = `CSWT_OFF_FLAGS_B;
  localparam logic [11:0] STA = `CSWT_OFF_STATUS;
  logic        pclk     = 1'h0;
  logic        presetn  = 1'h0;
  logic        psel     = 1'h0;
  logic        penable  = 1'h0;
  logic        pwrite   = 1'h0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [1:0]  dev_mode = 2'h0;
  logic        sleep_req = 1'h0;
  logic [3:0]  hs_fault = 4'h0;
  logic [2:0]  closed   = 3'h0;
  logic [2:0]  chatter  = 3'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err_bit, int_req_ff, supply_wake_ff;
  logic [3:0]  high_side_switch;
  logic [2:0]  wake_input_pin;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0, n_int = 0, n_wake = 0, base, hi, lo, k;

  always #2 pclk = ~pclk;

  cswt_top #(.TICK_CYC(TICK)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dev_mode(dev_mode),
    .sleep_req(sleep_req), .hs_fault(hs_fault),
    .wake_input_pin(wake_input_pin), .high_side_switch(high_side_switch),
    .int_req_ff(int_req_ff), .supply_wake_ff(supply_wake_ff)
  );
  cswt_wake_network net_u (
    .pclk(pclk), .closed(closed), .chatter(chatter),
    .wake_input_pin(wake_input_pin)
  );

  always @(posedge pclk) begin
    cycles++;
    if (int_req_ff === 1'h1) n_int++;
    if (supply_wake_ff === 1'h1) n_wake++;
    if (cycles == 100000) begin
      failures++;
      tally_and_finish();
    end
  end

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err_bit = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // ---------
  // Scenarios
  // ---------
  task t_reset;
    for (int a = 0; a < 32; a += 4) begin
      apb(1'h0, a[11:0], 32'h0);
      `CHK({err_bit, rd}, 33'h0)
    end
    apb(1'h0, 12'h020, 32'h0);
    `CHK({err_bit, rd}, 33'h100000000)
    apb(1'h1, 12'h006, 32'h5);
    apb(1'h0, `CSWT_OFF_SECOND_TIMER, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(high_side_switch, 4'h0)
  endtask

  task t_err;
    for (int i = 1; i < 6; i++) begin
      apb(1'h1, T1, 32'(i << 4));
      apb(1'h0, STA, 32'h0);
      `CHK(rd[0], i == 5)
    end
    apb(1'h1, T1, 32'h0);
    apb(1'h1, STA, 32'h1);
    apb(1'h0, STA, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  task t_pulse(input logic [6:0] cfg, input int on_t, input int per_t);
    apb(1'h1, T1, 32'h0);
    apb(1'h1, T1, {25'h0, cfg});
    hi = 0;
    lo = 0;
    while (high_side_switch[0] !== 1'h1) @(posedge pclk);
    while (high_side_switch[0] === 1'h1) begin
      @(posedge pclk);
      hi++;
    end
    while (high_side_switch[0] !== 1'h1) begin
      @(posedge pclk);
      lo++;
    end
    `CHK(hi, on_t * TICK)
    `CHK(lo, (per_t - on_t) * TICK)
    `CHK(high_side_switch[1], 1'h0)
  endtask

  task t_timing;
    apb(1'h1, MAP, 32'h9);
    t_pulse(7'h10, 1, 100);
    t_pulse(7'h20, 3, 100);
    t_pulse(7'h30, 10, 100);
    t_pulse(7'h11, 1, 200);
    t_pulse(7'h43, 100, 1000);
  endtask

  task t_idle;
    apb(1'h1, T1, 32'h70);
    apb(1'h1, `CSWT_OFF_SECOND_TIMER, 32'h70);
    repeat (3 * TICK) @(posedge pclk);
    `CHK(high_side_switch, 4'h3)
    dev_mode <= `CSWT_MODE_FAILSAFE;
    repeat (5) @(posedge pclk);
    `CHK(high_side_switch, 4'h0)
    dev_mode <= `CSWT_MODE_NORMAL;
    apb(1'h1, T1, 32'h0);
    apb(1'h1, `CSWT_OFF_SECOND_TIMER, 32'h0);
    repeat (3 * TICK) @(posedge pclk);
    `CHK(high_side_switch, 4'h0)
  endtask

  task t_wake;
    chatter <= 3'h4;
    apb(1'h1, MAP, 32'h1);
    apb(1'h1, T1, 32'h12);
    dev_mode <= `CSWT_MODE_STOP;
    base = n_int;
    repeat (12000) @(posedge pclk);
    apb(1'h0, FLA, 32'h0);
    `CHK(rd, 32'h0)
    closed <= 3'h2;
    apb(1'h0, `CSWT_OFF_LEVELS, 32'h0);
    `CHK(rd[1], 1'h1)
    for (k = 0; k < 12000 && n_int == base; k++) @(posedge pclk);
    repeat (3) @(posedge pclk);
    `CHK(n_int - base, 1)
    apb(1'h0, FLA, 32'h0);
    `CHK(rd, 32'h2)
    apb(1'h0, `CSWT_OFF_LEVELS, 32'h0);
    `CHK(rd[1:0], 2'h1)
    apb(1'h1, FLA, 32'h7);
    dev_mode <= `CSWT_MODE_SLEEP;
    closed <= 3'h0;
    base = n_wake;
    for (k = 0; k < 12000 && n_wake == base; k++) @(posedge pclk);
    `CHK(n_wake - base, 1)
    dev_mode <= `CSWT_MODE_NORMAL;
    apb(1'h0, FLA, 32'h0);
    `CHK(rd, 32'h2)
    // Flag left pending on purpose: sleep must bounce straight back
    dev_mode <= `CSWT_MODE_SLEEP;
    repeat (20) @(posedge pclk);
    `CHK(n_wake - base, 2)
    dev_mode <= `CSWT_MODE_NORMAL;
    apb(1'h0, STA, 32'h0);
    `CHK(rd[1], 1'h1)
    chatter <= 3'h0;
    apb(1'h1, FLA, 32'h7);
    apb(1'h1, STA, 32'h3);
  endtask

  task t_cwake;
    apb(1'h1, T1, 32'h0);
    apb(1'h1, `CSWT_OFF_SECOND_TIMER, 32'h0);
    apb(1'h1, `CSWT_OFF_WAKE_SRC, 32'h1);
    base = n_int;
    apb(1'h1, T1, 32'h10);
    repeat (300) @(posedge pclk);
    hs_fault <= 4'h1;
    hi = 0;
    repeat (3200) begin
      @(posedge pclk);
      if (high_side_switch[0] !== 1'h0) hi++;
    end
    `CHK(hi, 0)
    `CHK(n_int - base, 3)
    apb(1'h0, FLB, 32'h0);
    `CHK(rd, 32'h1)
    hs_fault <= 4'h0;
    apb(1'h1, T1, 32'h0);
    apb(1'h1, FLB, 32'h3);
    apb(1'h0, FLB, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  task tally_and_finish;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_err;
    t_timing;
    t_idle;
    t_wake;
    t_cwake;
    tally_and_finish;
  end
endmodule // cyclic_sense_wake_timer_bench
